// ### design/pse_map.svh
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH
// mode word fields
`define PSE_MD_SMART 5:1
`define PSE_MD_OE 6
`define PSE_MD_BINV 27
`define PSE_SM_USB 3'h6
`define PSE_SM_STX 5'h1c
`define PSE_SM_SRX 5'h1d
`define PSE_SM_ATX 5'h1e
`define PSE_SM_ARX 5'h1f
// parameter_x fields
`define PSE_X_LEN 4:0
`define PSE_X_UPD 5
`define PSE_X_NCO 15:0
`define PSE_X_WHOLE 31:16
`define PSE_X_FRAC 15:10
`define PSE_X_FZERO 31:26
// usb line commands written to parameter_y
`define PSE_Y_IDLE 8'h00
`define PSE_Y_SE0 8'h01
`define PSE_Y_K 8'h02
`define PSE_Y_J 8'h03
`define PSE_Y_EOP 8'h04
`define PSE_Y_SOP 8'h80
`define PSE_SYNC 8'h80
// usb bit-time counts
`define PSE_LINE_J_FS 2'h2
`define PSE_USB_LONG 3'h7
`define PSE_USB_SE0_ERR 3'h4
`define PSE_USB_STUFF 3'h6
`define PSE_EOP_J 2'h2
`define PSE_EOP_END 2'h3
`endif

// ### design/pse_pkg.sv
package pse_pkg;
    typedef enum logic [2:0] {OP_NONE, OP_MODE, OP_X, OP_Y, OP_RDACK, OP_RDQ, OP_ACK} pse_op_t;
    typedef struct packed {pse_op_t op; logic [31:0] data;} pse_cmd_t;
    typedef struct packed {logic flag; logic carry; logic [31:0] z;} pse_res_t;
    typedef struct packed {logic dp; logic dm;} pse_line_t;
    typedef enum logic [2:0] {SS_IDLE, SS_WLOW, SS_HALF, SS_STOP, SS_START, SS_DATA} pse_ser_t;
    typedef enum logic [1:0] {UT_LINE, UT_DATA, UT_EOP} pse_utx_t;
    typedef struct packed {
        logic [1:0] prev;
        logic [2:0] jr, kr, zr;
        logic [7:0] sh;
        logic [2:0] bc, ones;
        logic inp;
        logic [15:0] st;
    } pse_urx_t;
    typedef struct packed {
        logic [31:0] mode, x, z, sh, buff;
        logic flag, carry, oflag;
        logic [15:0] nco, usbst, bt;
        logic [5:0] facc;
        pse_utx_t utx;
        logic [7:0] ubuf, ush;
        logic ubfull, udrv, ulev;
        pse_line_t uline;
        logic [2:0] ubc, uones;
        logic [1:0] ueop;
        pse_ser_t ss;
        logic bfull, busy;
        logic [4:0] bcnt;
        logic breg, bprev, aprev, aprev2, edge_d;
        logic pin_out, pin_oe, dp_out, dp_oe, dm_out, dm_oe;
    } pse_st_t;
endpackage : pse_pkg

// ### design/pse_usb_rx.sv
`timescale 1ns/1ns
`include "pse_map.svh"
module pse_usb_rx import pse_pkg::*; (
    input logic clk_sys,
    input logic rst,
    input logic srst,
    input logic tick,
    input logic fs,
    input pse_line_t line,
    output logic [15:0] status
);
    pse_urx_t r, next_r;
    logic [1:0] jcode, lc;
    logic se0, se1, isj, isk, bit_v;
    logic [7:0] shv;
    logic [2:0] jn, kn, zn;

    always_comb begin
        next_r = r;
        jcode = fs ? `PSE_LINE_J_FS : ~`PSE_LINE_J_FS;
        lc = {line.dp, line.dm};
        se0 = lc == 2'h0;
        se1 = lc == 2'h3;
        isj = lc == jcode;
        isk = !se0 && !se1 && !isj;
        // nrzi: unchanged line is a one
        bit_v = lc == r.prev;
        shv = {bit_v, r.sh[7:1]};
        jn = !isj ? 3'h0 : (r.jr == 3'h7) ? 3'h7 : r.jr + 3'h1;
        kn = !isk ? 3'h0 : (r.kr == 3'h7) ? 3'h7 : r.kr + 3'h1;
        zn = !se0 ? 3'h0 : (r.zr == 3'h7) ? 3'h7 : r.zr + 3'h1;
        if (srst) begin
            next_r = '0;
            // all ones: a line leaving se0 never mimics the sync tail
            next_r.sh = 8'hff;
        end else if (tick) begin
            next_r.prev = lc;
            next_r.jr = jn;
            next_r.kr = kn;
            next_r.zr = zn;
            next_r.st[3] = se1;
            next_r.st[2] = se0;
            next_r.st[1] = kn == `PSE_USB_LONG;
            next_r.st[0] = jn == `PSE_USB_LONG;
            if (se1) begin
                next_r.st[6] = 1'b1;
            end
            if (jn == `PSE_USB_LONG || kn == `PSE_USB_LONG) begin
                next_r.st[5:4] = 2'h0;
            end
            if (se0) begin
                next_r.sh = 8'hff;
                if (r.inp) begin
                    next_r.inp = 1'b0;
                    next_r.st[5:4] = 2'h2;
                end
                if (zn == `PSE_USB_SE0_ERR && next_r.st[5]) begin
                    next_r.st[6] = 1'b1;
                end
            end else if (!se1) begin
                if (!r.inp) begin
                    next_r.sh = shv;
                    if (shv == `PSE_SYNC) begin
                        next_r.inp = 1'b1;
                        next_r.st[7:4] = 4'h1;
                        next_r.bc = 3'h0;
                        next_r.ones = 3'h0;
                    end
                end else if (r.ones == `PSE_USB_STUFF) begin
                    next_r.ones = 3'h0;
                    if (bit_v) begin
                        next_r.st[6] = 1'b1;
                    end
                end else begin
                    next_r.ones = bit_v ? r.ones + 3'h1 : 3'h0;
                    next_r.sh = shv;
                    next_r.bc = r.bc + 3'h1;
                    if (r.bc == 3'h7) begin
                        next_r.st[15:8] = shv;
                        next_r.st[7] = !r.st[7];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign status = r.st;
endmodule : pse_usb_rx

// ### design/pse_engine.sv
`timescale 1ns/1ns
`include "pse_map.svh"
// How it works
// - usb even pin flags any receiver status change; reads return 16-bit status.
// - usb bit clock is an nco adding a 16-bit fraction from parameter_x.
// - usb parameter_y 0 floats, 1 se0, 2 k, 3 j, 4 eop sequence.
// - usb parameter_y 0x80 sends sync, then bytes, eop once buffer runs dry.
// - usb actions act at next bit time; odd flag says buffer emptied.
// - usb receive and transmit are separate, sharing only the nco; rx sees own drive.
// - rx flag locks until mode, x or y write, acking read or ack; error to carry.
// - status 15:8 last byte, bit 7 toggles per byte, cleared at sop.
// - status bit 6 error: stuffing violation, long eop se0, or se1.
// - bit 5 eop, bit 4 sop, each clears other; 7 j/k clears both.
// - bits 3,2 se1/se0 after one bit; bits 1,0 k/j after seven.
// - sync tx shifts lsb first, two clocks after registered b rise; b invertible.
// - sync tx continuous mode reloads every word and raises flag.
// - sync tx start-stop writes go direct before first clock, else wait.
// - parameter_x 4:0 holds word length minus one.
// - sync tx reset passes writes into shifter, pin low, lsb on release.
// - sync rx samples a before, or with, the registered b edge per x bit 5.
// - sync rx word flagged and placed msb-aligned in result.
// - async bit period: x 31:16 whole clocks, 15:10 sixty-fourths if 31:26 zero.
// - async tx loads, flags, sends high, start, data lsb first, then high.
// - async tx busy into carry until nothing pending; pin high in reset.
// - async rx waits high, falling edge, rechecks at half bit, samples, flags.
module pse_engine import pse_pkg::*; (
    input logic clk_sys,
    input logic rst,
    input logic dir,
    input pse_cmd_t cmd,
    input logic a_in,
    input logic b_in,
    input pse_line_t usb_in,
    output pse_res_t res,
    output logic odd_flag,
    output logic pin_out,
    output logic pin_oe,
    output logic dp_out,
    output logic dp_oe,
    output logic dm_out,
    output logic dm_oe
);
    pse_st_t s, n;
    logic [4:0] sm, len;
    logic usb, fs, srst, ackev, ywr, redge, btick, utick, sbit;
    logic [5:0] fr;
    logic [6:0] fsum;
    logic [15:0] per;
    logic [16:0] usum;
    logic [1:0] jl;
    logic [31:0] shn;
    logic [15:0] urx_st;

    // rx watches the pads, which carry our own drive as well
    pse_usb_rx u_rx (
        .clk_sys(clk_sys),
        .rst(rst),
        .srst(srst || !usb),
        .tick(utick),
        .fs(fs),
        .line(usb_in),
        .status(urx_st)
    );

    always_comb begin
        n = s;
        sm = s.mode[`PSE_MD_SMART];
        usb = sm[4:2] == `PSE_SM_USB;
        fs = sm[0];
        len = s.x[`PSE_X_LEN];
        srst = !dir;
        ackev = cmd.op inside {OP_MODE, OP_X, OP_Y, OP_RDACK, OP_ACK};
        ywr = cmd.op == OP_Y;
        redge = s.breg && !s.bprev;
        btick = s.bt == 16'h0000;
        fr = (s.x[`PSE_X_FZERO] == 6'h00) ? s.x[`PSE_X_FRAC] : 6'h00;
        fsum = {1'b0, s.facc} + {1'b0, fr};
        per = s.x[`PSE_X_WHOLE] - 16'h0001 + {15'h0000, fsum[6]};
        usum = {1'b0, s.nco} + {1'b0, s.x[`PSE_X_NCO]};
        utick = usb && dir && usum[16];
        jl = fs ? `PSE_LINE_J_FS : ~`PSE_LINE_J_FS;
        shn = {1'b0, s.sh[31:1]};
        sbit = 1'b0;
        n.breg = b_in ^ s.mode[`PSE_MD_BINV];
        n.bprev = s.breg;
        n.aprev = a_in;
        n.aprev2 = s.aprev;
        n.edge_d = redge;
        if (!btick) begin
            n.bt = s.bt - 16'h0001;
        end
        if (ackev) begin
            n.flag = 1'b0;
        end
        if (cmd.op == OP_MODE) begin
            n.mode = cmd.data;
        end
        if (cmd.op == OP_X) begin
            n.x = cmd.data;
        end
        n.pin_oe = s.mode[`PSE_MD_OE] && !usb;
        n.dp_oe = 1'b0;
        n.dm_oe = 1'b0;
        n.pin_out = 1'b0;
        if (usb) begin
            n.nco = usum[15:0];
            n.usbst = urx_st;
            n.z = {16'h0000, urx_st};
            n.carry = urx_st[6];
            // a change seen while locked is dropped; an ack in the same cycle unlocks
            if (urx_st != s.usbst && (!s.flag || ackev)) begin
                n.flag = 1'b1;
            end
            if (ywr) begin
                n.oflag = 1'b0;
            end
            if (srst) begin
                n.utx = UT_LINE;
                n.udrv = 1'b0;
                n.nco = 16'h0000;
            end else if (utick) begin
                unique case (s.utx)
                    UT_LINE: begin
                        if (s.ubfull) begin
                            n.ubfull = 1'b0;
                            n.oflag = 1'b1;
                            n.udrv = 1'b1;
                            case (s.ubuf)
                                `PSE_Y_IDLE: n.udrv = 1'b0;
                                `PSE_Y_SE0: n.uline = 2'h0;
                                `PSE_Y_K: n.uline = ~jl;
                                `PSE_Y_J: n.uline = jl;
                                `PSE_Y_EOP: begin
                                    n.uline = 2'h0;
                                    n.ueop = 2'h1;
                                    n.utx = UT_EOP;
                                end
                                `PSE_Y_SOP: begin
                                    n.uline = jl;
                                    n.ulev = 1'b1;
                                    n.ush = `PSE_SYNC;
                                    n.ubc = 3'h0;
                                    n.uones = 3'h0;
                                    n.utx = UT_DATA;
                                end
                                default: n.udrv = s.udrv;
                            endcase
                        end
                    end
                    UT_DATA: begin
                        if (s.uones == `PSE_USB_STUFF) begin
                            n.ulev = !s.ulev;
                            n.uones = 3'h0;
                        end else begin
                            n.ulev = s.ush[0] ? s.ulev : !s.ulev;
                            n.uones = s.ush[0] ? s.uones + 3'h1 : 3'h0;
                            n.ush = {1'b0, s.ush[7:1]};
                            n.ubc = s.ubc + 3'h1;
                            if (s.ubc == 3'h7) begin
                                if (s.ubfull) begin
                                    n.ush = s.ubuf;
                                    n.ubfull = 1'b0;
                                    n.oflag = 1'b1;
                                end else begin
                                    n.ueop = 2'h0;
                                    n.utx = UT_EOP;
                                end
                            end
                        end
                        n.uline = n.ulev ? jl : ~jl;
                    end
                    UT_EOP: begin
                        n.ueop = s.ueop + 2'h1;
                        n.uline = (s.ueop == `PSE_EOP_J) ? jl : 2'h0;
                        if (s.ueop == `PSE_EOP_END) begin
                            n.udrv = 1'b0;
                            n.utx = UT_LINE;
                        end
                    end
                endcase
            end
            // a second write before the odd flag overwrites the pending one
            if (ywr) begin
                n.ubuf = cmd.data[7:0];
                n.ubfull = 1'b1;
            end
            n.dp_out = n.uline.dp;
            n.dm_out = n.uline.dm;
            n.dp_oe = n.udrv && s.mode[`PSE_MD_OE];
            n.dm_oe = n.udrv && s.mode[`PSE_MD_OE];
        end else begin
            case (sm)
                `PSE_SM_STX: begin
                    if (srst) begin
                        n.bcnt = 5'h00;
                        n.bfull = 1'b0;
                    end else if (s.edge_d) begin
                        n.sh = shn;
                        n.bcnt = s.bcnt + 5'h01;
                        if (s.bcnt == len) begin
                            n.bcnt = 5'h00;
                            if (!s.x[`PSE_X_UPD] || s.bfull) begin
                                n.sh = s.buff;
                                n.bfull = 1'b0;
                                n.flag = 1'b1;
                            end
                        end
                    end
                    if (ywr) begin
                        if (srst || (s.x[`PSE_X_UPD] && s.bcnt == 5'h00 && !s.edge_d)) begin
                            n.sh = cmd.data;
                        end else begin
                            n.buff = cmd.data;
                            n.bfull = 1'b1;
                        end
                    end
                    n.pin_out = !srst && n.sh[0];
                    n.carry = s.z[31];
                end
                `PSE_SM_SRX: begin
                    if (srst) begin
                        n.bcnt = 5'h00;
                    end else if (redge) begin
                        sbit = s.x[`PSE_X_UPD] ? s.aprev : s.aprev2;
                        n.sh = {sbit, s.sh[31:1]};
                        n.bcnt = s.bcnt + 5'h01;
                        if (s.bcnt == len) begin
                            n.bcnt = 5'h00;
                            n.z = {sbit, s.sh[31:1]};
                            n.flag = 1'b1;
                        end
                    end
                    n.carry = n.z[31];
                end
                `PSE_SM_ATX: begin
                    if (srst) begin
                        n.ss = SS_IDLE;
                    end else begin
                        unique case (s.ss)
                            SS_STOP: begin
                                if (btick) begin
                                    n.ss = SS_START;
                                    n.bt = per;
                                    n.facc = fsum[5:0];
                                end
                            end
                            SS_START: begin
                                if (btick) begin
                                    n.ss = SS_DATA;
                                    n.bcnt = 5'h00;
                                    n.bt = per;
                                    n.facc = fsum[5:0];
                                end
                            end
                            SS_DATA: begin
                                if (btick) begin
                                    n.sh = shn;
                                    n.bcnt = s.bcnt + 5'h01;
                                    n.bt = per;
                                    n.facc = fsum[5:0];
                                    if (s.bcnt == len) begin
                                        n.ss = SS_IDLE;
                                    end
                                end
                            end
                            default: begin
                                if (s.bfull) begin
                                    n.sh = s.buff;
                                    n.bfull = 1'b0;
                                    n.flag = 1'b1;
                                    n.ss = SS_STOP;
                                    n.bt = per;
                                    n.facc = fsum[5:0];
                                end else begin
                                    n.busy = 1'b0;
                                end
                            end
                        endcase
                    end
                    if (ywr) begin
                        n.buff = cmd.data;
                        n.bfull = 1'b1;
                        n.busy = 1'b1;
                    end
                    n.pin_out = srst || (n.ss == SS_DATA ? n.sh[0] : n.ss != SS_START);
                    n.carry = n.busy;
                end
                `PSE_SM_ARX: begin
                    if (srst) begin
                        n.ss = SS_IDLE;
                    end else begin
                        unique case (s.ss)
                            SS_WLOW: begin
                                if (!a_in) begin
                                    n.ss = SS_HALF;
                                    n.bt = {1'b0, s.x[31:17]};
                                    n.facc = 6'h00;
                                end
                            end
                            SS_HALF: begin
                                if (btick) begin
                                    n.ss = a_in ? SS_WLOW : SS_START;
                                    n.bt = per;
                                    n.facc = fsum[5:0];
                                end
                            end
                            SS_START: begin
                                if (btick) begin
                                    n.ss = SS_DATA;
                                    n.bcnt = 5'h00;
                                end
                            end
                            SS_DATA: begin
                                if (btick) begin
                                    n.sh = {a_in, s.sh[31:1]};
                                    n.bcnt = s.bcnt + 5'h01;
                                    n.bt = per;
                                    n.facc = fsum[5:0];
                                    if (s.bcnt == len) begin
                                        n.z = {a_in, s.sh[31:1]};
                                        n.flag = 1'b1;
                                        n.ss = SS_IDLE;
                                    end
                                end
                            end
                            default: begin
                                if (a_in) begin
                                    n.ss = SS_WLOW;
                                end
                            end
                        endcase
                    end
                    n.carry = n.z[31];
                end
                default: n.carry = s.z[31];
            endcase
        end
        if (srst) begin
            n.flag = 1'b0;
            n.oflag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign res = {s.flag, s.carry, s.z};
    assign odd_flag = s.oflag;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign dp_out = s.dp_out;
    assign dp_oe = s.dp_oe;
    assign dm_out = s.dm_out;
    assign dm_oe = s.dm_oe;
endmodule : pse_engine

// ### test/pse_engine_props.sv
`timescale 1ns/1ns
`include "pse_map.svh"
module pse_engine_props import pse_pkg::*; (
    input logic clk_sys,
    input logic rst,
    input logic dir,
    input pse_cmd_t cmd,
    input pse_res_t res,
    input logic odd_flag,
    input logic pin_out,
    input logic pin_oe,
    input logic dp_oe,
    input logic dm_oe
);
    logic [31:0] mode_q;
    logic usb, stx, atx;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) mode_q <= 32'h0;
        else if (cmd.op == OP_MODE) mode_q <= cmd.data;
    end
    assign usb = mode_q[5:3] == `PSE_SM_USB;
    assign stx = mode_q[`PSE_MD_SMART] == `PSE_SM_STX;
    assign atx = mode_q[`PSE_MD_SMART] == `PSE_SM_ATX;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_stx_rst; (stx && !dir) [*2]; endsequence
    sequence s_atx_rst; (atx && !dir) [*2]; endsequence
    property p_stx_low; s_stx_rst |-> !pin_out; endproperty
    property p_atx_high; s_atx_rst |-> pin_out; endproperty
    property p_zhi; usb && $past(usb) |-> res.z[31:16] == 16'h0; endproperty
    property p_carry; usb && $past(usb) |-> res.carry == res.z[6]; endproperty
    property p_nodrv; !mode_q[6] && !$past(mode_q[6]) |-> !(dp_oe || dm_oe || pin_oe); endproperty
    property p_rst_flag; !dir |=> !res.flag && !odd_flag; endproperty
    property p_hold; dir && res.flag && !(cmd.op inside {OP_MODE, OP_X, OP_Y, OP_RDACK, OP_ACK}) |=> res.flag;
    endproperty
    property p_odd; usb && cmd.op == OP_Y |=> !odd_flag; endproperty
    property p_rise; usb && dir && $past(usb) && $past(dir) && $changed(res.z[15:0]) |-> ##[0:2] res.flag;
    endproperty
    a_stx_low: assert property (p_stx_low) else $error("sync pin not low");
    a_atx_high: assert property (p_atx_high) else $error("async pin not high");
    a_zhi: assert property (p_zhi) else $error("status upper bits set");
    a_carry: assert property (p_carry) else $error("carry not error bit");
    a_nodrv: assert property (p_nodrv) else $error("drive without enable");
    a_rst_flag: assert property (p_rst_flag) else $error("flag in reset");
    a_hold: assert property (p_hold) else $error("flag dropped");
    a_odd: assert property (p_odd) else $error("odd flag kept");
    a_rise: assert property (p_rise) else $error("no flag on status change");
endmodule : pse_engine_props
bind pse_engine pse_engine_props i_pse_engine_props (.clk_sys(clk_sys), .rst(rst), .dir(dir), .cmd(cmd),
    .res(res), .odd_flag(odd_flag), .pin_out(pin_out), .pin_oe(pin_oe), .dp_oe(dp_oe), .dm_oe(dm_oe));

// ### test/pse_peer.sv
`timescale 1ns/1ns
module pse_peer #(
    parameter int BIT = 10
) (
    input logic clk_sys,
    input logic rx,
    output logic tx
);
    logic [7:0] got;
    int cnt;
    initial begin
        tx = 1'b1;
        cnt = 0;
    end
    // mid-bit sampling absorbs the engine's registered launch
    always begin
        wait (rx === 1'b1);
        @(negedge rx);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_sys);
            got[i] = rx;
        end
        cnt++;
    end
    task send(input logic [7:0] d);
        tx = 1'b0;
        repeat (BIT) @(posedge clk_sys) #1;
        for (int j = 0; j < 8; j++) begin
            tx = d[j];
            repeat (BIT) @(posedge clk_sys) #1;
        end
        tx = 1'b1;
        repeat (BIT) @(posedge clk_sys) #1;
    endtask : send
endmodule : pse_peer

// ### test/pin_serial_usb_engine_test.sv
`timescale 1ns/1ns
module pin_serial_usb_engine_test import pse_pkg::*; ;
    typedef struct {int m; logic [7:0] d; logic [3:0] e;} pse_row_t;
    logic clk_sys, rst, dir, a_in, b_in, odd_flag, pin_out, pin_oe, dp_out, dp_oe, dm_out, dm_oe;
    pse_cmd_t cmd;
    pse_res_t res;
    pse_line_t usb_in;
    int n_errors, n_tests, nrx;
    logic [7:0] d;
    pse_row_t rows [8] = '{'{0, 8'ha5, 4'h0}, '{0, 8'hff, 4'h0}, '{1, 8'h3c, 4'h0}, '{1, 8'h81, 4'h0},
        '{2, 8'h00, 4'h0}, '{2, 8'h01, 4'hc}, '{2, 8'h02, 4'hd}, '{2, 8'h03, 4'he}};
    logic [31:0] modes [3] = '{32'h7c, 32'h3e, 32'h72};
    logic [31:0] xs [3] = '{32'h000a0007, 32'h000a0007, 32'h00008000};
    // dp pull-up of an attached full-speed device: a floated pair reads J
    assign usb_in = '{dp: dp_oe ? dp_out : 1'b1, dm: dm_oe ? dm_out : 1'b0};
    pse_engine i_pse_engine (.clk_sys(clk_sys), .rst(rst), .dir(dir), .cmd(cmd), .a_in(a_in), .b_in(b_in),
        .usb_in(usb_in), .res(res), .odd_flag(odd_flag), .pin_out(pin_out), .pin_oe(pin_oe), .dp_out(dp_out),
        .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe));
    pse_peer i_pse_peer (.clk_sys(clk_sys), .rx(pin_out), .tx(a_in));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk_sys) #1;
    endtask : cyc
    task op(input pse_op_t o, input logic [31:0] v);
        cmd = '{o, v};
        cyc(1);
        cmd = '{OP_NONE, 32'h0};
        cyc(1);
    endtask : op
    task wt(input int w, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            if (w == 0 ? res.flag === 1'b1 : w == 1 ? odd_flag === 1'b1 : i_pse_peer.cnt == nrx) break;
            cyc(1);
        end
        if (i == n) begin
            n_errors++;
            conclude();
        end
    endtask : wt
    task conclude();
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'b1;
        dir = 1'b0;
        b_in = 1'b0;
        cmd = '{OP_NONE, 32'h0};
        n_errors = 0;
        n_tests = 0;
        nrx = 0;
        cyc(8);
        rst = 1'b0;
        chk("rst_outs", {res.flag, res.carry, odd_flag, pin_out, pin_oe, dp_oe, dm_oe}, 0);
        foreach (rows[r]) begin
            if (r == 0 || rows[r].m != rows[r - 1].m) begin
                dir = 1'b0;
                op(OP_MODE, modes[rows[r].m]);
                op(OP_X, xs[rows[r].m]);
                if (rows[r].m == 0) chk("atx_idle", pin_out, 1);
                dir = 1'b1;
                cyc(2);
            end
            d = rows[r].d;
            case (rows[r].m)
                0: begin
                    nrx++;
                    op(OP_Y, d);
                    cyc(2);
                    chk("atx_load", {res.flag, res.carry}, 2'b11);
                    wt(2, 300);
                    chk("atx_data", i_pse_peer.got, d);
                    cyc(30);
                    chk("atx_busy", res.carry, 0);
                    op(OP_RDACK, 0);
                end
                1: begin
                    i_pse_peer.send(d);
                    cyc(3);
                    chk("arx_word", res.z, {d, (rows[r - 1].m == 1 ? rows[r - 1].d : 8'h00), 16'h0});
                    chk("arx_flag", res.flag, 1);
                    op(OP_RDACK, 0);
                end
                default: begin
                    op(OP_Y, d);
                    wt(1, 40);
                    cyc(1);
                    chk("usb_line", {dp_oe, dm_oe, dp_out & dp_oe, dm_out & dm_oe}, rows[r].e);
                end
            endcase
        end
        cyc(40);
        chk("usb_idle", {res.z[31:16], res.z[5:0]}, {16'h0, 6'h01});
        chk("usb_flag", res.flag, 1);
        op(OP_RDACK, 0);
        cyc(2);
        chk("usb_ack", res.flag, 0);
        op(OP_Y, 32'h80);
        wt(1, 40);
        op(OP_Y, 32'hc3);
        wt(1, 80);
        cyc(120);
        chk("usb_pkt", {res.z[15:6], res.carry}, {8'hc3, 2'b10, 1'b0});
        dir = 1'b0;
        op(OP_MODE, 32'h78);
        op(OP_X, 32'h27);
        op(OP_Y, 32'h69);
        chk("stx_rst", pin_out, 0);
        dir = 1'b1;
        cyc(2);
        chk("stx_lsb", pin_out, 1);
        chk("stx_oe", pin_oe, 1);
        for (int i = 1; i < 9; i++) begin
            b_in = 1'b1;
            cyc(4);
            chk("stx_bit", pin_out, i < 8 ? 32'h69 >> i & 1 : 0);
            b_in = 1'b0;
            if (i == 2) op(OP_Y, 32'h0);
            else cyc(2);
        end
        chk("stx_flag", res.flag, 1);
        op(OP_MODE, 32'h3a);
        op(OP_X, 32'h3);
        for (int i = 0; i < 4; i++) begin
            i_pse_peer.tx = i[0];
            cyc(2);
            b_in = 1'b1;
            cyc(2);
            b_in = 1'b0;
            cyc(2);
        end
        chk("srx_word", res.z, 32'ha0000000);
        chk("srx_flag", res.flag, 1);
        conclude();
    end
endmodule : pin_serial_usb_engine_test
